// [rtl/tdc_regs_pkg.sv]
// Register map, field layouts and reset values of the converter control bank.
// Assumes nothing; shared by the register bank module.
package tdc_regs_pkg;
   // -------------------------------------------------------------------
   // Register offsets from the active base address
   // -------------------------------------------------------------------
   localparam logic [15:0] OFF_RELOC_HIGH   = 16'h1004;
   localparam logic [15:0] OFF_RELOC_LOW    = 16'h1006;
   localparam logic [15:0] OFF_RELOC_EN     = 16'h1008;
   localparam logic [15:0] OFF_IRQ_LEVEL    = 16'h100a;
   localparam logic [15:0] OFF_IRQ_VECTOR   = 16'h100c;
   localparam logic [15:0] OFF_SLOT_ADDR    = 16'h100e;
   localparam logic [15:0] OFF_GROUP_BASE   = 16'h1010;
   localparam logic [15:0] OFF_CHAIN_CTRL   = 16'h1012;
   localparam logic [15:0] OFF_MOD_RESET    = 16'h1014;
   localparam logic [15:0] OFF_SOFT_CLEAR   = 16'h1016;
   localparam logic [15:0] OFF_EVENT_RESET  = 16'h1018;
   localparam logic [15:0] OFF_SOFT_TRIG    = 16'h101a;
   localparam logic [15:0] OFF_TRIG_COUNT   = 16'h101c;
   localparam logic [15:0] OFF_EVENTS_HELD  = 16'h1020;
   localparam logic [15:0] OFF_NEAR_FULL    = 16'h1022;
   localparam logic [15:0] OFF_QUOTA        = 16'h1024;
   localparam logic [15:0] OFF_FW_REV       = 16'h1026;
   localparam logic [15:0] OFF_TEST_WORD    = 16'h1028;

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [2:0]  RST_IRQ_LEVEL    = 3'h0;
   localparam logic [7:0]  RST_IRQ_VECTOR   = 8'hdd;
   localparam logic [4:0]  RST_SLOT_ADDR    = 5'h1f;
   localparam logic [7:0]  RST_GROUP_BASE   = 8'haa;
   localparam logic [7:0]  RST_RELOC        = 8'h00;
   localparam logic [1:0]  RST_CHAIN        = 2'h0;
   localparam logic [15:0] RST_NEAR_FULL    = 16'h0040;
   localparam logic [7:0]  RST_QUOTA        = 8'h00;

   // Chain position encodings
   localparam logic [1:0]  CHAIN_OFF        = 2'h0;
   localparam logic [1:0]  CHAIN_LAST       = 2'h1;
   localparam logic [1:0]  CHAIN_FIRST      = 2'h2;
   localparam logic [1:0]  CHAIN_MIDDLE     = 2'h3;
endpackage

// [rtl/vme_tdc_control_register_bank.sv]
// Control register bank of a multihit time converter module.
// Assumes a bus front end that delivers decoded cycles as one-cycle read or
// write pulses with full address, synchronous to i_ref_clk (20 MHz).
// Operation
// - Upper relocation register holds address bits 31..24, read and write.
// - Lower relocation register holds address bits 23..16, read and write.
// - Relocation select bit picks rotary switch (0) or relocation registers (1).
// - After relocation only the new base address answers bus cycles.
// - Slot address is not changed by base relocation.
// - Interrupt level is low three bits; zero disables interrupts.
// - Acknowledge cycle returns eight-bit vector, default 0xdd.
// - Five-bit slot address resets to all ones; software loads it.
// - Group base register gives multicast address, default 0xaa.
// - Two chain bits: off, first, last or intermediate position.
// - Any access to module reset location gives one reset pulse.
// - Soft clear clears converters, buffer, event counter, global reset.
// - Event reset write issues converter event reset.
// - Software trigger write gives one trigger like external trigger.
// - 32-bit trigger count, cleared by reset or clear, trigger matching only.
// - Read-only register reports complete events held in buffer.
// - Word count at or above threshold sets near-full flag and interrupt.
// - Threshold range 1 to 32735, default 64; software keeps range.
// - Threshold accepts sixteen-bit accesses and multicast writes.
// - Eight-bit events per transfer, zero disables; sixteen-bit access.
// - Firmware revision: major upper nibble, minor lower nibble.
// - In buffer test mode each test word write is pushed to buffer.
// - In buffer test mode converter data is kept out of buffer.
// - Control bit selects buffer test mode, default off.
`timescale 1ns/1ps
module vme_tdc_control_register_bank #(
   parameter logic [7:0] FW_REVISION = 8'h10  // Arbitrary value
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   // Decoded bus cycles
   input  wire logic [31:0] i_bus_addr,
   input  wire logic        i_bus_wr,
   input  wire logic        i_bus_rd,
   input  wire logic [31:0] i_bus_wdata,
   input  wire logic        i_iack,
   input  wire logic [2:0]  i_iack_level,
   output logic [31:0]      o_bus_rdata,
   output logic             o_bus_ack,
   // Switches and core status
   input  wire logic [15:0] i_rotary_base,
   input  wire logic        i_ext_trigger,
   input  wire logic        i_trig_match_mode,
   input  wire logic [15:0] i_buf_word_count,
   input  wire logic [15:0] i_buf_event_count,
   input  wire logic        i_buffer_test_en,
   input  wire logic        i_conv_data_valid,
   // Outputs to the core
   output logic             o_module_reset,
   output logic             o_converter_clear,
   output logic             o_buffer_clear,
   output logic             o_converter_global_reset,
   output logic             o_event_reset,
   output logic             o_trigger,
   output logic             o_near_full,
   output logic             o_irq_req,
   output logic [2:0]       o_irq_level,
   output logic [4:0]       o_slot_address,
   output logic [7:0]       o_group_base_address,
   output logic [1:0]       o_chain_position,
   output logic [15:0]      o_near_full_value,
   output logic [7:0]       o_transfer_event_quota,
   output logic             o_test_push,
   output logic [31:0]      o_test_word,
   output logic             o_conv_data_accept
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic [7:0]  reloc_high_reg;
   logic [7:0]  reloc_low_reg;
   logic        reloc_en_reg;
   logic [2:0]  irq_level_reg;
   logic [7:0]  irq_vector_reg;
   logic [4:0]  slot_address_reg;
   logic [7:0]  group_base_reg;
   logic [1:0]  chain_reg;
   logic [15:0] near_full_value_reg;
   logic [7:0]  quota_reg;
   logic [31:0] trig_count_reg;
   logic [31:0] test_word_reg;
   logic [31:0] rdata_reg;
   logic        ack_reg;
   logic        mod_reset_reg;
   logic        soft_clear_reg;
   logic        event_reset_reg;
   logic        trigger_reg;
   logic        test_push_reg;
   logic        near_full_reg;

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   function automatic logic hit(input logic [15:0] off, input logic [15:0] target);
      hit = (off == target);
   endfunction

   // Base source follows the select bit; old base stops matching at once
   wire [15:0] active_base  = reloc_en_reg ? {reloc_high_reg, reloc_low_reg}
                                           : i_rotary_base;
   wire        base_match   = (i_bus_addr[31:16] == active_base);
   wire [15:0] off          = i_bus_addr[15:0];
   // Multicast writes use the group base on the top byte only
   wire        mcast_match  = (chain_reg != tdc_regs_pkg::CHAIN_OFF) &&
                              (i_bus_addr[31:24] == group_base_reg);
   wire        mc_wr        = i_bus_wr && mcast_match && !base_match;
   wire        wr           = i_bus_wr && base_match;
   wire        rd           = i_bus_rd && base_match;
   wire        acc          = wr || rd;

   wire h_rh   = hit(off, tdc_regs_pkg::OFF_RELOC_HIGH);
   wire h_rl   = hit(off, tdc_regs_pkg::OFF_RELOC_LOW);
   wire h_re   = hit(off, tdc_regs_pkg::OFF_RELOC_EN);
   wire h_il   = hit(off, tdc_regs_pkg::OFF_IRQ_LEVEL);
   wire h_iv   = hit(off, tdc_regs_pkg::OFF_IRQ_VECTOR);
   wire h_sa   = hit(off, tdc_regs_pkg::OFF_SLOT_ADDR);
   wire h_gb   = hit(off, tdc_regs_pkg::OFF_GROUP_BASE);
   wire h_cc   = hit(off, tdc_regs_pkg::OFF_CHAIN_CTRL);
   wire h_mr   = hit(off, tdc_regs_pkg::OFF_MOD_RESET);
   wire h_sc   = hit(off, tdc_regs_pkg::OFF_SOFT_CLEAR);
   wire h_er   = hit(off, tdc_regs_pkg::OFF_EVENT_RESET);
   wire h_st   = hit(off, tdc_regs_pkg::OFF_SOFT_TRIG);
   wire h_tc   = hit(off, tdc_regs_pkg::OFF_TRIG_COUNT);
   wire h_eh   = hit(off, tdc_regs_pkg::OFF_EVENTS_HELD);
   wire h_nf   = hit(off, tdc_regs_pkg::OFF_NEAR_FULL);
   wire h_q    = hit(off, tdc_regs_pkg::OFF_QUOTA);
   wire h_fw   = hit(off, tdc_regs_pkg::OFF_FW_REV);
   wire h_tw   = hit(off, tdc_regs_pkg::OFF_TEST_WORD);
   wire mapped = h_rh | h_rl | h_re | h_il | h_iv | h_sa | h_gb | h_cc | h_mr | h_sc
               | h_er | h_st | h_tc | h_eh | h_nf | h_q | h_fw | h_tw;

   // Strobes: module reset on any access, others on writes only
   wire mod_reset_hit  = acc && h_mr;
   wire soft_clear_hit = wr && h_sc;
   wire evt_reset_hit  = wr && h_er;
   wire soft_trig_hit  = wr && h_st;
   wire test_push_hit  = wr && h_tw && i_buffer_test_en;
   // Threshold and quota also take multicast writes
   wire nf_wr          = (wr || mc_wr) && h_nf;
   wire q_wr           = (wr || mc_wr) && h_q;

   // Interrupt acknowledge answers only on the programmed, nonzero level
   wire iack_hit = i_iack && o_irq_req && (i_iack_level == irq_level_reg);
   wire any_trig = i_ext_trigger || soft_trig_hit;

   // -------------------------------------------------------------------
   // Read data selection
   // -------------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (iack_hit) begin
         rd_mux = {24'h00_0000, irq_vector_reg};
      end else if (h_rh) begin
         rd_mux = {24'h00_0000, reloc_high_reg};
      end else if (h_rl) begin
         rd_mux = {24'h00_0000, reloc_low_reg};
      end else if (h_il) begin
         rd_mux = {29'h0000_0000, irq_level_reg};
      end else if (h_iv) begin
         rd_mux = {24'h00_0000, irq_vector_reg};
      end else if (h_sa) begin
         rd_mux = {27'h000_0000, slot_address_reg};
      end else if (h_gb) begin
         rd_mux = {24'h00_0000, group_base_reg};
      end else if (h_cc) begin
         rd_mux = {30'h0000_0000, chain_reg};
      end else if (h_tc) begin
         rd_mux = trig_count_reg;
      end else if (h_eh) begin
         rd_mux = {16'h0000, i_buf_event_count};
      end else if (h_nf) begin
         rd_mux = {16'h0000, near_full_value_reg};
      end else if (h_q) begin
         rd_mux = {24'h00_0000, quota_reg};
      end else if (h_fw) begin
         rd_mux = {24'h00_0000, FW_REVISION};
      end else if (h_tw) begin
         rd_mux = test_word_reg;
      end
   end

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   // Module reset restores defaults the cycle after its pulse
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reloc_high_reg      <= tdc_regs_pkg::RST_RELOC;
         reloc_low_reg       <= tdc_regs_pkg::RST_RELOC;
         reloc_en_reg        <= 1'b0;
         irq_level_reg       <= tdc_regs_pkg::RST_IRQ_LEVEL;
         irq_vector_reg      <= tdc_regs_pkg::RST_IRQ_VECTOR;
         slot_address_reg    <= tdc_regs_pkg::RST_SLOT_ADDR;
         group_base_reg      <= tdc_regs_pkg::RST_GROUP_BASE;
         chain_reg           <= tdc_regs_pkg::RST_CHAIN;
         near_full_value_reg <= tdc_regs_pkg::RST_NEAR_FULL;
         quota_reg           <= tdc_regs_pkg::RST_QUOTA;
         test_word_reg       <= 32'h0000_0000;
      end else if (mod_reset_reg) begin
         reloc_high_reg      <= tdc_regs_pkg::RST_RELOC;
         reloc_low_reg       <= tdc_regs_pkg::RST_RELOC;
         reloc_en_reg        <= 1'b0;
         irq_level_reg       <= tdc_regs_pkg::RST_IRQ_LEVEL;
         irq_vector_reg      <= tdc_regs_pkg::RST_IRQ_VECTOR;
         slot_address_reg    <= tdc_regs_pkg::RST_SLOT_ADDR;
         group_base_reg      <= tdc_regs_pkg::RST_GROUP_BASE;
         chain_reg           <= tdc_regs_pkg::RST_CHAIN;
         near_full_value_reg <= tdc_regs_pkg::RST_NEAR_FULL;
         quota_reg           <= tdc_regs_pkg::RST_QUOTA;
         test_word_reg       <= 32'h0000_0000;
      end else begin
         if (wr && h_rh) reloc_high_reg <= i_bus_wdata[7:0];
         if (wr && h_rl) reloc_low_reg <= i_bus_wdata[7:0];
         if (wr && h_re) reloc_en_reg <= i_bus_wdata[0];
         if (wr && h_il) irq_level_reg <= i_bus_wdata[2:0];
         if (wr && h_iv) irq_vector_reg <= i_bus_wdata[7:0];
         if (wr && h_sa) slot_address_reg <= i_bus_wdata[4:0];
         if (wr && h_gb) group_base_reg <= i_bus_wdata[7:0];
         if (wr && h_cc) chain_reg <= i_bus_wdata[1:0];
         if (nf_wr) near_full_value_reg <= i_bus_wdata[15:0];
         if (q_wr) quota_reg <= i_bus_wdata[7:0];
         if (wr && h_tw) test_word_reg <= i_bus_wdata;
      end
   end

   // -------------------------------------------------------------------
   // Bus answer and strobes
   // -------------------------------------------------------------------
   // Unmapped offsets get no acknowledge except on multicast writes and interrupt acknowledge cycles, so the master times out
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_reg         <= 1'b0;
         rdata_reg       <= 32'h0000_0000;
         mod_reset_reg   <= 1'b0;
         soft_clear_reg  <= 1'b0;
         event_reset_reg <= 1'b0;
         trigger_reg     <= 1'b0;
         test_push_reg   <= 1'b0;
      end else begin
         ack_reg         <= (acc && mapped) || mc_wr || iack_hit;
         rdata_reg       <= rd_mux;
         mod_reset_reg   <= mod_reset_hit;
         soft_clear_reg  <= soft_clear_hit;
         event_reset_reg <= evt_reset_hit;
         trigger_reg     <= any_trig;
         test_push_reg   <= test_push_hit;
      end
   end

   // -------------------------------------------------------------------
   // Trigger counter and near-full flag
   // -------------------------------------------------------------------
   // Clear and module reset win over a coincident trigger
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         trig_count_reg <= 32'h0000_0000;
         near_full_reg  <= 1'b0;
      end else begin
         if (soft_clear_hit || mod_reset_reg) begin
            trig_count_reg <= 32'h0000_0000;
         end else if (any_trig && i_trig_match_mode) begin
            trig_count_reg <= trig_count_reg + 32'h0000_0001;
         end
         near_full_reg <= (i_buf_word_count >= near_full_value_reg);
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign o_bus_ack                = ack_reg;
   assign o_bus_rdata              = rdata_reg;
   assign o_module_reset           = mod_reset_reg;
   assign o_converter_clear        = soft_clear_reg;
   assign o_buffer_clear           = soft_clear_reg;
   assign o_converter_global_reset = soft_clear_reg;
   assign o_event_reset            = event_reset_reg;
   assign o_trigger                = trigger_reg;
   assign o_near_full              = near_full_reg;
   // Level zero holds the request low whatever the flag does
   assign o_irq_req                = near_full_reg && (irq_level_reg != 3'h0);
   assign o_irq_level              = irq_level_reg;
   assign o_slot_address           = slot_address_reg;
   assign o_group_base_address     = group_base_reg;
   assign o_chain_position         = chain_reg;
   assign o_near_full_value        = near_full_value_reg;
   assign o_transfer_event_quota   = quota_reg;
   assign o_test_push              = test_push_reg;
   assign o_test_word              = test_word_reg;
   // Converter data held back while test words own the buffer
   assign o_conv_data_accept       = i_conv_data_valid && !i_buffer_test_en;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   a_reloc_high_rw: assert property ((wr && h_rh && !mod_reset_reg) |=>
      reloc_high_reg == $past(i_bus_wdata[7:0])) else $error("reloc high not stored");
   a_reloc_low_rw: assert property ((wr && h_rl && !mod_reset_reg) |=>
      reloc_low_reg == $past(i_bus_wdata[7:0])) else $error("reloc low not stored");
   a_base_select: assert property (reloc_en_reg |->
      active_base == {reloc_high_reg, reloc_low_reg}) else $error("wrong base source");
   a_old_base_dead: assert property ((i_bus_rd && !base_match && !i_iack) |=>
      !o_bus_ack) else $error("foreign address acknowledged");
   a_irq_level_zero: assert property ((irq_level_reg == 3'h0) |-> !o_irq_req)
      else $error("interrupt with level zero");
   a_iack_vector: assert property (iack_hit |=>
      (o_bus_ack && o_bus_rdata[7:0] == $past(irq_vector_reg))) else $error("bad vector");
   a_modreset_pulse: assert property (mod_reset_hit |=> o_module_reset ##1
      (!o_module_reset || $past(mod_reset_hit))) else $error("module reset not single");
   a_modreset_dflt: assert property (o_module_reset |=>
      (irq_vector_reg == tdc_regs_pkg::RST_IRQ_VECTOR &&
       slot_address_reg == tdc_regs_pkg::RST_SLOT_ADDR)) else $error("defaults not restored");
   a_clear_counter: assert property (soft_clear_hit |=>
      (trig_count_reg == 32'h0000_0000 && o_buffer_clear)) else $error("clear failed");
   a_count_mode: assert property ((any_trig && !i_trig_match_mode) |=>
      $stable(trig_count_reg) || $past(soft_clear_hit || mod_reset_reg))
      else $error("count moved outside matching mode");
   a_near_full: assert property (##1 (o_near_full ==
      ($past(i_buf_word_count) >= $past(near_full_value_reg)))) else $error("near-full wrong");
   a_test_block: assert property (i_buffer_test_en |-> !o_conv_data_accept)
      else $error("converter data passed in test mode");
   a_test_push: assert property ((wr && h_tw && i_buffer_test_en) |=>
      (o_test_push && o_test_word == $past(i_bus_wdata))) else $error("test push missing");

   // Bus stores, reads and strobes; a coincident module reset wins over stores, so the store checks exclude it

   a_event_reset: assert property ((wr && h_er) |=> o_event_reset)
      else $error("event reset missing");

   a_soft_trigger: assert property (soft_trig_hit |=> o_trigger)
      else $error("soft trigger missing");

   a_count_step: assert property ((any_trig && i_trig_match_mode && !soft_clear_hit
      && !mod_reset_reg) |=> trig_count_reg == $past(trig_count_reg) + 32'h0000_0001)
      else $error("count did not step");

   a_events_held: assert property ((rd && h_eh && !i_iack) |=>
      o_bus_rdata == {16'h0000, $past(i_buf_event_count)}) else $error("bad event count");

   a_fw_revision: assert property ((rd && h_fw && !i_iack) |=>
      o_bus_rdata == {24'h00_0000, FW_REVISION}) else $error("bad revision");

   a_mcast_threshold: assert property ((mc_wr && h_nf && !mod_reset_reg) |=>
      near_full_value_reg == $past(i_bus_wdata[15:0])) else $error("threshold not stored");

   a_quota_store: assert property ((q_wr && !mod_reset_reg) |=>
      quota_reg == $past(i_bus_wdata[7:0])) else $error("quota not stored");

   a_chain_store: assert property ((wr && h_cc && !mod_reset_reg) |=>
      chain_reg == $past(i_bus_wdata[1:0])) else $error("chain bits not stored");

   a_slot_kept: assert property ((wr && h_re && !mod_reset_reg) |=>
      $stable(slot_address_reg)) else $error("slot moved on relocation");

   a_unmapped_quiet: assert property ((i_bus_rd && !mapped && !i_iack) |=>
      !o_bus_ack) else $error("unmapped offset acknowledged");

   a_strobe_read: assert property ((rd && h_st && !i_ext_trigger) |=>
      !o_trigger) else $error("strobe read had an effect");

   a_test_no_push: assert property ((wr && h_tw && !i_buffer_test_en) |=>
      !o_test_push) else $error("push outside test mode");
endmodule // vme_tdc_control_register_bank

// [testbench/bus_master_model.sv]
// Bus master model: issues one decoded register cycle at a time.
// Assumes the bank answers exactly one cycle after taking a request.
`timescale 1ns/1ps
module bus_master_model (
   input  wire logic   i_ref_clk,
   input  wire logic   i_bus_ack,
   output logic [31:0] o_addr,
   output logic        o_wr = 1'b0,
   output logic        o_rd = 1'b0,
   output logic [31:0] o_wdata,
   output logic        o_iack = 1'b0,
   output logic [2:0]  o_iack_level
);
   // ---------------------------------------------------------------
   // One-cycle request, answer sampled mid-cycle
   // ---------------------------------------------------------------
   // Released strobes drop to zero; address, data and level show the inverse, so stale values cannot match
   task automatic cyc(input logic [2:0] wri, input logic [31:0] a, input logic [31:0] d,
                      output logic acked);
      @(posedge i_ref_clk);
      #1;
      {o_wr, o_rd, o_iack} = wri;
      {o_addr, o_wdata, o_iack_level} = {a, d, d[2:0]};
      @(posedge i_ref_clk);
      #1;
      {o_wr, o_rd, o_iack} = 3'h0;
      {o_addr, o_wdata, o_iack_level} = {~a, ~d, ~d[2:0]};
      @(negedge i_ref_clk);
      acked = i_bus_ack;
   endtask
endmodule // bus_master_model

// [testbench/tb_top.sv]
// Self-checking bench of the control register bank.
// Assumes the bus master model in its own file; one 20 MHz clock.
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] FW = 8'h21;  // Arbitrary value
   logic i_ref_clk = 0, i_rst_n = 0, ext = 0, mm = 0, tst = 0, cv = 0, ack, push, acc;
   logic [31:0] addr, wd, rdata, tw, rnd;
   logic wr, rd, ia, trg, nf, irq, mr, cc, bc, gr, er;
   logic [2:0] il, lvl;
   logic [15:0] rot, wc = 0, ec = 0, base, nb;
   logic [4:0] slot;
   logic [7:0] grp, quota;
   logic [1:0] chain;
   logic [15:0] nfv;
   logic [32:0] exp_q[$];
   int num_errors = 0, check_count = 0, cyc_cnt = 0;
   always #25 i_ref_clk = ~i_ref_clk;
   bus_master_model i_master (.i_ref_clk(i_ref_clk), .i_bus_ack(ack), .o_addr(addr),
      .o_wr(wr), .o_rd(rd), .o_wdata(wd), .o_iack(ia), .o_iack_level(il));
   vme_tdc_control_register_bank #(.FW_REVISION(FW)) i_dut (.i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n), .i_bus_addr(addr), .i_bus_wr(wr), .i_bus_rd(rd), .i_bus_wdata(wd),
      .i_iack(ia), .i_iack_level(il), .o_bus_rdata(rdata), .o_bus_ack(ack),
      .i_rotary_base(rot), .i_ext_trigger(ext), .i_trig_match_mode(mm),
      .i_buf_word_count(wc), .i_buf_event_count(ec), .i_buffer_test_en(tst),
      .i_conv_data_valid(cv), .o_module_reset(mr), .o_converter_clear(cc),
      .o_buffer_clear(bc), .o_converter_global_reset(gr), .o_event_reset(er),
      .o_trigger(trg), .o_near_full(nf), .o_irq_req(irq), .o_irq_level(lvl),
      .o_slot_address(slot), .o_group_base_address(grp), .o_chain_position(chain),
      .o_near_full_value(nfv), .o_transfer_event_quota(quota), .o_test_push(push),
      .o_test_word(tw), .o_conv_data_accept(acc));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      check_count++;
      if (got !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task automatic step();
      @(posedge i_ref_clk);
      #1;
   endtask
   // Note the answer first, then run the cycle; unanswered cycles note nothing
   task automatic op(input logic [2:0] k, input logic [15:0] off, input logic [31:0] d,
                     input logic [32:0] note, input logic ea);
      logic a;
      if (ea) exp_q.push_back(note);
      i_master.cyc(k, {base, off}, d, a);
      chk(32'(a), 32'(ea));
   endtask
   // Answer watcher: oldest note against each acknowledged cycle
   always @(negedge i_ref_clk) begin
      if (ack === 1'b1) begin
         if (exp_q.size() == 0) chk(32'h1, 32'h0);
         else if (exp_q[0][32]) chk(rdata, exp_q[0][31:0]);
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Hang guard, ceiling well above the hundred or so cycles used
   always @(posedge i_ref_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 3000) begin
         num_errors++;
         test_done();
      end
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      rnd = lfsr(32'h66d2);
      rot = rnd[15:0];
      base = rot;
      repeat (2) @(posedge i_ref_clk);
      #1 i_rst_n = 1;
      chk({lvl, slot, grp, chain, nfv, quota}, {3'h0, 5'h1f, 8'haa, 2'h0, 16'h40, 8'h0});
      op(3'h2, 16'h1026, 32'h0, {1'b1, 24'h0, FW}, 1'b1);
      op(3'h2, 16'h1002, 32'h0, 33'h0, 1'b0);
      op(3'h4, 16'h100a, 32'hfffa, 33'h0, 1'b1);
      op(3'h2, 16'h100a, 32'h0, {1'b1, 32'h2}, 1'b1);
      op(3'h4, 16'h1022, 32'h5, 33'h0, 1'b1);
      step();
      wc = 16'h4;
      repeat (3) step();
      chk(32'({nf, irq}), 32'h0);
      wc = 16'h5;
      repeat (3) step();
      chk(32'({nf, irq}), 32'h3);
      op(3'h1, 16'h0, 32'h1, 33'h0, 1'b0);
      op(3'h1, 16'h0, 32'h2, {1'b1, 32'hdd}, 1'b1);
      op(3'h4, 16'h100c, 32'hff3c, 33'h0, 1'b1);
      op(3'h1, 16'h0, 32'h2, {1'b1, 32'h3c}, 1'b1);
      $display("test irq done");
      step();
      mm = 1;
      op(3'h4, 16'h101a, 32'h0, 33'h0, 1'b1);
      chk(32'(trg), 32'h1);
      op(3'h4, 16'h101a, 32'h0, 33'h0, 1'b1);
      step();
      ext = 1;
      step();
      ext = 0;
      mm = 0;
      op(3'h4, 16'h101a, 32'h0, 33'h0, 1'b1);
      op(3'h2, 16'h101c, 32'h0, {1'b1, 32'h3}, 1'b1);
      op(3'h4, 16'h1016, 32'h0, 33'h0, 1'b1);
      chk(32'({cc, bc, gr}), 32'h7);
      op(3'h4, 16'h1018, 32'h0, 33'h0, 1'b1);
      chk(32'(er), 32'h1);
      step();
      mm = 1;
      op(3'h2, 16'h101a, 32'h0, {1'b1, 32'h0}, 1'b1);
      op(3'h2, 16'h101c, 32'h0, {1'b1, 32'h0}, 1'b1);
      $display("test trigger done");
      step();
      tst = 1;
      cv = 1;
      rnd = lfsr(rnd);
      ec = ~rnd[15:0];
      op(3'h2, 16'h1020, 32'h0, {1'b1, 16'h0, ec}, 1'b1);
      op(3'h4, 16'h1028, rnd, 33'h0, 1'b1);
      chk({31'h0, push} ^ tw, 32'h1 ^ rnd);
      chk(32'(acc), 32'h0);
      step();
      tst = 0;
      op(3'h4, 16'h1028, ~rnd, 33'h0, 1'b1);
      chk(32'({push, acc}), 32'h1);
      for (int i = 3; i >= 0; i--) begin
         op(3'h4, 16'h1012, 32'(i), 33'h0, 1'b1);
         chk(32'(chain), 32'(i));
         if (i == 2) begin
            nb = base;
            base = {8'haa, ~nb[7:0]};
            op(3'h4, 16'h1022, 32'h77, 33'h0, 1'b1);
            chk(32'(nfv), 32'h77);
            op(3'h4, 16'h1024, 32'h33, 33'h0, 1'b1);
            chk(32'(quota), 32'h33);
            base = nb;
            op(3'h2, 16'h1024, 32'h0, {1'b1, 32'h33}, 1'b1);
         end
      end
      $display("test chain done");
      rnd = lfsr(rnd);
      op(3'h4, 16'h1004, 32'(rnd[7:0]), 33'h0, 1'b1);
      op(3'h4, 16'h1006, 32'(rnd[15:8]), 33'h0, 1'b1);
      op(3'h2, 16'h1004, 32'h0, {1'b1, 24'h0, rnd[7:0]}, 1'b1);
      op(3'h2, 16'h1006, 32'h0, {1'b1, 24'h0, rnd[15:8]}, 1'b1);
      op(3'h4, 16'h100e, 32'h7, 33'h0, 1'b1);
      op(3'h4, 16'h1008, 32'h1, 33'h0, 1'b1);
      op(3'h2, 16'h100a, 32'h0, 33'h0, 1'b0);
      base = {rnd[7:0], rnd[15:8]};
      op(3'h2, 16'h100a, 32'h0, {1'b1, 32'h2}, 1'b1);
      chk(32'(slot), 32'h7);
      op(3'h2, 16'h1014, 32'h0, {1'b1, 32'h0}, 1'b1);
      chk(32'(mr), 32'h1);
      step();
      chk({lvl, slot, nfv}, {3'h0, 5'h1f, 16'h40});
      base = rot;
      op(3'h2, 16'h100a, 32'h0, {1'b1, 32'h0}, 1'b1);
      $display("test relocation done");
      test_done();
   end
endmodule // tb_top
